//--- pkg/uart_mcls_pkg.sv
// Shared constants and types for the modem control / line status block.
// Assumes a 32-bit APB slave with word-aligned registers.
package uart_mcls_pkg;

  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam int          INDEX_W       = ADDR_W - 2;

  // Register indices; byte address is four times the index
  localparam logic [9:0]  CTRL_INDEX     = 10'h004;
  localparam logic [9:0]  FLAGS_INDEX    = 10'h005;

  // modem_line_control fields
  localparam int          CTRL_DTR       = 0;
  localparam int          CTRL_RTS       = 1;
  localparam int          CTRL_USER1     = 2;
  localparam int          CTRL_USER2     = 3;
  localparam int          CTRL_LOOP      = 4;
  localparam int          CTRL_AUTO_FLOW = 5;
  localparam int          CTRL_HALF_STOP = 7;
  localparam logic [7:0]  CTRL_RW_MASK   = 8'hBF;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;

  // line_state_flags fields
  localparam int          FLG_RX_AVAIL   = 0;
  localparam int          FLG_ERR_LO     = 1;
  localparam int          FLG_ERR_HI     = 4;
  localparam int          FLG_THR_EMPTY  = 5;
  localparam int          FLG_TSR_EMPTY  = 6;
  localparam int          FLG_FIFO_ERR   = 7;

  // Sticky error vector order: overrun, parity, framing, break
  localparam int          ERR_W         = 4;
  localparam logic [3:0]  ERR_RESET     = 4'h0;

  // Stop gap timing in 16x sample ticks
  localparam int          TICKS_PER_BIT = 16;
  localparam int          GAP_CNT_W     = 6;
  localparam logic [5:0]  TICKS_PER_HALF = 6'(TICKS_PER_BIT / 2);
  localparam logic [2:0]  HALVES_ONE    = 3'h2;
  localparam logic [2:0]  HALVES_1P5    = 3'h3;
  localparam logic [2:0]  HALVES_TWO    = 3'h4;
  localparam logic [2:0]  HALVES_ENH    = 3'h1;

  localparam int          SYNC_W        = 2;

  typedef enum logic [1:0] {
    GAP_IDLE = 2'b00,
    GAP_RUN  = 2'b01,
    GAP_DONE = 2'b10
  } gap_state_t;

endpackage

//--- pkg/stop_gap_if.sv
// Link between the control block and its stop gap timer.
// Assumes both ends run on pclk.
`timescale 1ns/1ns
interface stop_gap_if;
  logic tick;
  logic start;
  logic enhanced;
  logic stop_sel;
  logic len5;
  logic busy;
  logic done;

  modport ctl (
    output tick,
    output start,
    output enhanced,
    output stop_sel,
    output len5,
    input  busy,
    input  done
  );

  modport timer (
    input  tick,
    input  start,
    input  enhanced,
    input  stop_sel,
    input  len5,
    output busy,
    output done
  );
endinterface

//--- src/stop_gap_timer.sv
// Times the stop gap placed between two transmitted characters.
// Assumes tick is a one-cycle 16x sample enable on pclk.
`timescale 1ns/1ns
module stop_gap_timer
  import uart_mcls_pkg::*;
(
  input  wire logic  pclk,
  input  wire logic  presetn,
  stop_gap_if.timer  gap
);

  typedef struct packed {
    gap_state_t           st;
    logic [GAP_CNT_W-1:0] ticks;
  } gap_reg_t;

  gap_reg_t s;
  gap_reg_t next_s;

  // Length of the gap in half bit times
  function automatic logic [2:0] gap_halves(input logic enh, input logic sel, input logic l5);
    logic [2:0] h;
    h = HALVES_ONE;
    if (enh) begin
      h = HALVES_ENH;                                         // [RULE11]
    end else if (sel) begin
      h = l5 ? HALVES_1P5 : HALVES_TWO;                       // [RULE10]
    end
    return h;
  endfunction

  always_comb begin
    next_s = s;
    case (s.st)
      GAP_IDLE: begin
        if (gap.start) begin
          next_s.st    = GAP_RUN;
          next_s.ticks = GAP_CNT_W'(gap_halves(gap.enhanced, gap.stop_sel, gap.len5) * TICKS_PER_HALF);
        end
      end
      GAP_RUN: begin
        if (gap.tick) begin
          if (s.ticks == GAP_CNT_W'(1)) begin
            next_s.st = GAP_DONE;
          end
          next_s.ticks = s.ticks - GAP_CNT_W'(1);
        end
      end
      GAP_DONE: begin
        next_s.st = GAP_IDLE;
      end
      default: begin
        next_s.st = GAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{st: GAP_IDLE, ticks: '0};
    end else begin
      s <= next_s;
    end
  end

  assign gap.busy = (s.st != GAP_IDLE);
  assign gap.done = (s.st == GAP_DONE);

endmodule

//--- src/uart_modem_line_ctrl.sv
// Modem control and line status logic for one UART channel, APB slave.
// Assumes the transmitter, receiver and receive FIFO sit outside on pclk,
// and that the modem pins arrive asynchronously.
//
// Notes on behaviour
// RULE1 - DTR pin high when control bit 0 clear, low when set; resets clear.
// RULE2 - RTS pin high when control bit 1 clear, low when set, unless auto.
// RULE3 - In internal loopback, user output one drives the internal RI input.
// RULE4 - In internal loopback, user output two drives the internal DCD input.
// RULE5 - Control bit 4 selects internal loopback; resets clear.
// RULE6 - Auto-flow enable clear gives diagnostic mode: transmitted data is received.
// RULE7 - Auto-flow enable and RTS bit set: auto-RTS and auto-CTS both on.
// RULE8 - Auto-flow enable set, RTS bit clear: only auto-CTS, RTS stays manual.
// RULE9 - Auto-flow enable clear: both automatic flow controls off.
// RULE10 - Control bit 7 clear: normal 1, 1.5 or 2 stop bits per line format.
// RULE11 - Control bit 7 set: half a stop bit between characters.
// RULE12 - Status bit 0 is one while the receive FIFO holds data.
// RULE13 - Status bit 1 flags a receive overrun.
// RULE14 - Status bits 2 and 3 flag parity and framing errors.
// RULE15 - Status bit 4 flags a detected break on the receive line.
// RULE16 - Status bit 5 is one when the transmit holding register is empty.
// RULE17 - Status bit 6 is one when the transmit shift register is empty.
// RULE18 - Status bit 7 is one when any character in the FIFO has an error.
// RULE19 - Error flags stay set until the status register is read.
// RULE20 - Loopback routes transmit data to receiver; external handshakes held inactive.
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
module uart_modem_line_ctrl
  import uart_mcls_pkg::*;
(
  // APB slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Modem pins, asynchronous inputs
  input  wire logic              rx_pin,
  input  wire logic              cts_n_pin,
  input  wire logic              ri_n_pin,
  input  wire logic              dcd_n_pin,
  output logic                   tx_pin,
  output logic                   dtr_pin,
  output logic                   rts_pin,
  // Transmitter side, same clock
  input  wire logic              tx_serial,
  input  wire logic              thr_empty,
  input  wire logic              tsr_empty,
  input  wire logic              gap_req,
  input  wire logic              sample_tick,
  input  wire logic              stop_sel,
  input  wire logic              len5,
  output logic                   gap_busy,
  output logic                   gap_done,
  output logic                   tx_allowed,
  // Receiver side, same clock
  input  wire logic              rx_fifo_nonempty,
  input  wire logic              rx_fifo_room,
  input  wire logic              rx_fifo_has_error,
  input  wire logic              overrun_ev,
  input  wire logic              parity_ev,
  input  wire logic              framing_ev,
  input  wire logic              break_ev,
  output logic                   rx_to_receiver,
  output logic                   ri_n_to_core,
  output logic                   dcd_n_to_core,
  output logic                   auto_rts_en,
  output logic                   auto_cts_en
);

  typedef struct packed {
    logic [7:0]        ctrl;
    logic [ERR_W-1:0]  err;
    logic [SYNC_W-1:0] rx_s;
    logic [SYNC_W-1:0] cts_s;
    logic [SYNC_W-1:0] ri_s;
    logic [SYNC_W-1:0] dcd_s;
    logic [7:0]        rdata;
    logic              serr;
  } ctl_reg_t;

  ctl_reg_t          s;
  ctl_reg_t          next_s;
  logic [ERR_W-1:0]  err_ev;
  logic [ERR_W-1:0]  err_view;
  logic [INDEX_W-1:0] idx;
  logic              setup_ph;
  logic              access_ph;
  logic              loop_on;
  logic              aflow_on;

  stop_gap_if gif ();

  // Word index of a byte address
  function automatic logic [INDEX_W-1:0] reg_index(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  function automatic logic is_mapped(input logic [INDEX_W-1:0] i);
    return (i == CTRL_INDEX) || (i == FLAGS_INDEX);
  endfunction

  // Assembles the status byte from live levels and sticky errors
  function automatic logic [7:0] flags_value(input logic [ERR_W-1:0] e);
    logic [7:0] v;
    v = '0;
    v[FLG_RX_AVAIL]            = rx_fifo_nonempty;     // [RULE12]
    v[FLG_ERR_HI:FLG_ERR_LO]   = e;                    // [RULE13] [RULE14] [RULE15]
    v[FLG_THR_EMPTY]           = thr_empty;            // [RULE16]
    v[FLG_TSR_EMPTY]           = tsr_empty;            // [RULE17]
    v[FLG_FIFO_ERR]            = rx_fifo_has_error;    // [RULE18]
    return v;
  endfunction

  assign idx       = reg_index(paddr);
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign err_ev    = {break_ev, framing_ev, parity_ev, overrun_ev};
  // Errors arriving now are already visible, so a read never loses them
  assign err_view  = s.err | err_ev;

  always_comb begin
    next_s = s;

    // Two-stage synchronisers for the pins
    next_s.rx_s  = {s.rx_s[0], rx_pin};
    next_s.cts_s = {s.cts_s[0], cts_n_pin};
    next_s.ri_s  = {s.ri_s[0], ri_n_pin};
    next_s.dcd_s = {s.dcd_s[0], dcd_n_pin};

    // Read data is captured in the setup phase, answered with no wait state
    if (setup_ph) begin
      next_s.serr  = !is_mapped(idx);
      next_s.rdata = '0;
      if (idx == CTRL_INDEX) begin
        next_s.rdata = s.ctrl;
      end else if (idx == FLAGS_INDEX) begin
        next_s.rdata = flags_value(err_view);
      end
    end

    // Completing a status read clears the sticky errors; new events win
    if (access_ph && !pwrite && (idx == FLAGS_INDEX)) begin
      next_s.err = '0;                                  // [RULE19]
    end
    next_s.err = next_s.err | err_ev;                   // [RULE19]

    // Reserved bit 6 is never stored
    if (access_ph && pwrite && (idx == CTRL_INDEX) && pstrb[0]) begin
      next_s.ctrl = pwdata[7:0] & CTRL_RW_MASK;         // [RULE5]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{ctrl:  CTRL_RESET,                         // [RULE1] [RULE5]
             err:   ERR_RESET,
             rx_s:  '1,
             cts_s: '1,
             ri_s:  '1,
             dcd_s: '1,
             rdata: '0,
             serr:  1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign prdata  = {{(DATA_W-8){1'b0}}, s.rdata};
  assign pready  = 1'b1;
  assign pslverr = access_ph && s.serr;

  assign loop_on  = s.ctrl[CTRL_LOOP];                  // [RULE5]
  assign aflow_on = s.ctrl[CTRL_AUTO_FLOW];

  // Flow control selection
  assign auto_rts_en = aflow_on && s.ctrl[CTRL_RTS];    // [RULE7] [RULE9]
  assign auto_cts_en = aflow_on;                        // [RULE8] [RULE9]

  // Handshake pins are active low; loopback parks them inactive
  always_comb begin
    if (loop_on) begin
      dtr_pin = 1'b1;                                   // [RULE20]
      rts_pin = 1'b1;                                   // [RULE20]
      tx_pin  = 1'b1;                                   // [RULE20]
    end else begin
      dtr_pin = !s.ctrl[CTRL_DTR];                      // [RULE1]
      tx_pin  = tx_serial;
      if (auto_rts_en) begin
        rts_pin = !rx_fifo_room;                        // [RULE7]
      end else begin
        rts_pin = !s.ctrl[CTRL_RTS];                    // [RULE2] [RULE8]
      end
    end
  end

  // Receive path: internal echo in loopback or diagnostic mode
  assign rx_to_receiver = (loop_on || !aflow_on) ? tx_serial : s.rx_s[1];  // [RULE6] [RULE20]

  // User outputs drive the internal modem inputs in loopback
  assign ri_n_to_core  = loop_on ? s.ctrl[CTRL_USER1] : s.ri_s[1];       // [RULE3]
  assign dcd_n_to_core = loop_on ? s.ctrl[CTRL_USER2] : s.dcd_s[1];      // [RULE4]

  // Auto-CTS holds the transmitter while the remote deasserts CTS
  assign tx_allowed = !auto_cts_en || loop_on || !s.cts_s[1];            // [RULE7] [RULE8]

  // Stop gap between characters
  assign gif.tick     = sample_tick;
  assign gif.start    = gap_req;
  assign gif.enhanced = s.ctrl[CTRL_HALF_STOP];         // [RULE10] [RULE11]
  assign gif.stop_sel = stop_sel;
  assign gif.len5     = len5;
  assign gap_busy     = gif.busy;
  assign gap_done     = gif.done;

  stop_gap_timer u_gap (
    .pclk    (pclk),
    .presetn (presetn),
    .gap     (gif.timer)
  );

endmodule

//--- tb/uart_modem_line_ctrl_assertions.sv
// Checker for the modem control / line status block, bound to its top.
// Assumes pready is always high, so an access cycle is one clock long.
`timescale 1ns/1ns
module uart_modem_line_ctrl_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        dtr_pin,
  input wire logic        rts_pin,
  input wire logic        tx_pin,
  input wire logic        tx_serial,
  input wire logic        ri_n_to_core,
  input wire logic        dcd_n_to_core,
  input wire logic        rx_to_receiver,
  input wire logic        auto_rts_en,
  input wire logic        auto_cts_en,
  input wire logic        rx_fifo_nonempty,
  input wire logic        rx_fifo_has_error,
  input wire logic        thr_empty,
  input wire logic        tsr_empty,
  input wire logic        parity_ev,
  input wire logic        gap_req,
  input wire logic        gap_busy,
  input wire logic        gap_done
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire ctl_wr   = psel && penable && pwrite && paddr == 12'h010 && pstrb[0];
  wire flags_rd = psel && !penable && !pwrite && paddr == 12'h014;
  AST_DTR: assert property (ctl_wr && !pwdata[4] |=> dtr_pin == !$past(pwdata[0]))
    else $error("dtr pin wrong after control write");
  AST_RTS: assert property (ctl_wr && !pwdata[4] && !pwdata[5] |=> rts_pin == !$past(pwdata[1]))
    else $error("rts pin wrong after control write");
  AST_LOOP: assert property (ctl_wr && pwdata[4] |=> ri_n_to_core == $past(pwdata[2])
    && dcd_n_to_core == $past(pwdata[3])) else $error("loopback user outputs not routed");
  AST_LOOP_PINS: assert property (ctl_wr && pwdata[4] |=> dtr_pin && rts_pin && tx_pin)
    else $error("pins not inactive in loopback");
  AST_AUTO: assert property (ctl_wr |=> auto_cts_en == $past(pwdata[5])
    && auto_rts_en == ($past(pwdata[5]) && $past(pwdata[1]))) else $error("auto flow selection wrong");
  AST_DIAG: assert property (!auto_cts_en |-> rx_to_receiver == tx_serial)
    else $error("diagnostic echo missing");
  AST_FLAGS: assert property (flags_rd |=> prdata[0] == $past(rx_fifo_nonempty)
    && prdata[5] == $past(thr_empty) && prdata[6] == $past(tsr_empty)
    && prdata[7] == $past(rx_fifo_has_error)) else $error("status levels wrong");
  AST_PARITY: assert property (parity_ev ##1 flags_rd |=> prdata[2])
    else $error("parity flag lost before read");
  AST_GAP_RUN: assert property (gap_req && !gap_busy |=> gap_busy [*8])
    else $error("stop gap ended too soon");
  AST_GAP_END: assert property (gap_done |=> !gap_busy)
    else $error("stop gap busy after done");
  cover property (ctl_wr && pwdata[4]);
  cover property (gap_done);
  cover property (parity_ev ##1 flags_rd);
endmodule
bind uart_modem_line_ctrl uart_modem_line_ctrl_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .dtr_pin, .rts_pin, .tx_pin, .tx_serial, .ri_n_to_core, .dcd_n_to_core,
  .rx_to_receiver, .auto_rts_en, .auto_cts_en, .rx_fifo_nonempty, .rx_fifo_has_error, .thr_empty,
  .tsr_empty, .parity_ev, .gap_req, .gap_busy, .gap_done);

//--- tb/remote_dte_model.sv
// Remote serial equipment on the handshake lines.
// Assumes stall is driven by the bench to hold the remote off.
`timescale 1ns/1ns
module remote_dte_model #(
  parameter int LAG = 3
) (
  input  wire logic pclk,
  input  wire logic dtr_pin,
  input  wire logic rts_pin,
  input  wire logic tx_pin,
  input  wire logic stall,
  output logic      rx_pin,
  output logic      cts_n_pin,
  output logic      ri_n_pin,
  output logic      dcd_n_pin
);
  logic [LAG-1:0] rts_q = '1;
  // Clear to send follows our request after a lag, or is held off
  always @(posedge pclk) rts_q <= {rts_q[LAG-2:0], rts_pin};
  assign cts_n_pin = stall | rts_q[LAG-1];
  // Remote sends the inverse of what it hears, so echo and line differ
  assign rx_pin    = ~tx_pin;
  assign ri_n_pin  = dtr_pin;
  assign dcd_n_pin = ~dtr_pin;
endmodule

//--- tb/tb_uart_modem_line_ctrl.sv
// Self-checking bench for the modem control / line status block.
// Assumes the remote model on the pins and an APB master in the bench.
`timescale 1ns/1ns
module tb_uart_modem_line_ctrl;
  import uart_mcls_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, stall, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [31:0] seed = 32'h62C8CCDB;
  logic [3:0]  pstrb, ev;
  logic        rx_pin, cts_n_pin, ri_n_pin, dcd_n_pin, tx_pin, dtr_pin, rts_pin, lp, dtr_e, rts_e;
  logic        tx_serial, thr_empty, tsr_empty, gap_req, sample_tick, stop_sel, len5, gap_busy, gap_done;
  logic        rx_fifo_nonempty, rx_fifo_room, rx_fifo_has_error, tx_allowed, rx_to_receiver;
  logic        ri_n_to_core, dcd_n_to_core, auto_rts_en, auto_cts_en;
  int          n_fail, checked, ctl, n;
  int          tbl[4] = '{'h22, 'h20, 'h1E, 'h3C};
  uart_modem_line_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .rx_pin, .cts_n_pin, .ri_n_pin, .dcd_n_pin, .tx_pin, .dtr_pin, .rts_pin, .tx_serial,
    .thr_empty, .tsr_empty, .gap_req, .sample_tick, .stop_sel, .len5, .gap_busy, .gap_done, .tx_allowed,
    .rx_fifo_nonempty, .rx_fifo_room, .rx_fifo_has_error, .overrun_ev(ev[0]), .parity_ev(ev[1]),
    .framing_ev(ev[2]), .break_ev(ev[3]), .rx_to_receiver, .ri_n_to_core, .dcd_n_to_core, .auto_rts_en,
    .auto_cts_en);
  remote_dte_model dte_u (.pclk, .dtr_pin, .rts_pin, .tx_pin, .stall, .rx_pin, .cts_n_pin, .ri_n_pin,
    .dcd_n_pin);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic chk_rd(string s, logic [31:0] e);
    chk(s, e, rd);
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] st = 4'hF);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic test_done();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #100000;
    n_fail++;
    test_done();
  end
  initial begin
    {psel, penable, pwrite, gap_req, sample_tick, stop_sel, len5, stall, tx_serial} = '0;
    {thr_empty, tsr_empty, rx_fifo_nonempty, rx_fifo_room, rx_fifo_has_error} = '0;
    {paddr, pwdata, ev, presetn, n_fail, checked} = '0;
    pstrb = 4'hF;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk("dtr", 1, dtr_pin);
    apb(0, 12'h010, 0);
    chk_rd("ctl", 0);
    apb(0, 12'h040, 0);
    chk("slverr", 1, err);
    chk_rd("unmapped", 0);
    apb(1, 12'h010, 32'hFF, 4'h0);
    apb(0, 12'h010, 0);
    chk_rd("strobe", 0);
    for (int k = 0; k < 20; k++) begin
      v = k < 4 ? tbl[k] : xs();
      apb(1, 12'h010, v);
      ctl = v & 'hBF;
      {tx_serial, rx_fifo_room, stall} <= 3'(xs());
      repeat (10) @(posedge pclk);
      lp = ctl[4];
      dtr_e = lp | !ctl[0];
      rts_e = lp | ((ctl[5] & ctl[1]) ? !rx_fifo_room : !ctl[1]);
      chk("dtr", dtr_e, dtr_pin);
      chk("rts", rts_e, rts_pin);
      chk("ri", lp ? ctl[2] : dtr_e, ri_n_to_core);
      chk("dcd", lp ? ctl[3] : !dtr_e, dcd_n_to_core);
      chk("txp", lp | tx_serial, tx_pin);
      chk("rxr", (lp | !ctl[5]) ? tx_serial : !tx_serial, rx_to_receiver);
      chk("arts", ctl[5] & ctl[1], auto_rts_en);
      chk("acts", ctl[5], auto_cts_en);
      chk("txa", !(ctl[5] & !lp & (stall | rts_e)), tx_allowed);
      apb(0, 12'h010, 0);
      chk_rd("ctl", ctl);
    end
    // Reset in mid-run returns the control register and pins to rest
    presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk("rst dtr", 1, dtr_pin);
    apb(0, 12'h010, 0);
    chk_rd("rst ctl", 0);
    for (int i = 0; i < 4; i++) begin
      {thr_empty, tsr_empty, rx_fifo_nonempty, rx_fifo_has_error} <= 4'(xs());
      ev <= 4'(1 << i);
      @(posedge pclk);
      ev <= 0;
      apb(0, 12'h014, 0);
      v = {24'h0, rx_fifo_has_error, tsr_empty, thr_empty, 4'(1 << i), rx_fifo_nonempty};
      chk_rd("flags", v);
      apb(0, 12'h014, 0);
      chk_rd("cleared", {rx_fifo_has_error, tsr_empty, thr_empty, 4'h0, rx_fifo_nonempty});
    end
    // Half, one, one and a half, two stop bits: i + 1 halves of 8 ticks
    for (int i = 0; i < 4; i++) begin
      apb(1, 12'h010, i == 0 ? 32'h80 : 32'h0);
      stop_sel <= i > 1;
      len5 <= i == 2;
      gap_req <= 1;
      @(posedge pclk);
      for (n = 1; n < 80; n++) begin
        sample_tick <= 1;
        gap_req <= n == 3;
        @(posedge pclk);
        sample_tick <= 0;
        gap_req <= 0;
        @(negedge pclk);
        if (gap_done === 1'b1) break;
        @(posedge pclk);
      end
      chk("gap", 8 * (i + 1), n);
      @(posedge pclk);
    end
    test_done();
  end
endmodule
